// ### hdl/flash_ctrl_pkg.sv
// Constants and types shared by the flash timer and mode control block.
package flash_ctrl_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] DURATION_OFFSET = 8'h05; // Flash duration
    localparam logic [7:0] CONTROL_OFFSET  = 8'h06; // Mode and enable
    localparam logic [7:0] DURATION_RESET  = 8'h23; // 72 ms
    localparam logic [7:0] READ_NONE       = 8'h00; // Unmapped read

    // Control register field positions
    localparam int MODE_LSB   = 0;
    localparam int MODE_MSB   = 1;
    localparam int RSVD_BIT   = 2;
    localparam int OUT_ON_BIT = 3;

    // ---------------------------------------------------------------
    // Operating modes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SHUTDOWN  = 2'b00,
        MODE_INDICATOR = 2'b01,
        MODE_ASSIST    = 2'b10,
        MODE_FLASH     = 2'b11
    } op_mode_t;

    localparam logic [1:0] EXT_TORCH_SEL = 2'h2; // Selector value 10

    // Current level masks per mode
    localparam logic [7:0] MASK_LOW6 = 8'h3f;
    localparam logic [7:0] MASK_LOW7 = 8'h7f;
    localparam logic [7:0] MASK_FULL = 8'hff;

    // ---------------------------------------------------------------
    // Duration encoding
    // ---------------------------------------------------------------
    localparam logic [10:0] SHORT_STEP_MS  = 11'h002; // 2 ms steps
    localparam logic [10:0] LONG_STEP_MS   = 11'h008; // 8 ms steps
    localparam logic [10:0] LONG_BASE_CODE = 11'h07f; // 127
    localparam logic [10:0] LONG_BASE_MS   = 11'h100; // 256 ms

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ      = 125_000_000;
    localparam int MS_PER_S    = 1000;
    localparam int MS_CYCLES   = CLK_HZ / MS_PER_S;   // 125000
    localparam int PWM_HZ      = 31_250;              // 31.25 kHz
    localparam int PWM_CYCLES  = CLK_HZ / PWM_HZ;     // 4000
    localparam int DUTY_STEPS  = 16;                  // Sixteenths
    localparam int SLOT_CYCLES = PWM_CYCLES / DUTY_STEPS; // 250

endpackage

// ### hdl/flash_period_timer.sv
// Millisecond flash period timer with its own millisecond divider.
`timescale 1ns/1ps
module flash_period_timer
    import flash_ctrl_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Control
    input  wire logic        run,
    input  wire logic [10:0] limit_ms,
    // Status
    output logic             expired,
    output logic [10:0]      elapsed_ms
);

    localparam int DW = $clog2(MS_CYCLES_P + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(MS_CYCLES_P - 1);

    // ---------------------------------------------------------------
    // Divider and millisecond counter
    // ---------------------------------------------------------------
    logic [DW-1:0] div_q,  div_d;   // Cycle count within a millisecond
    logic [10:0]   ms_q,   ms_d;    // Whole milliseconds elapsed
    logic          exp_q,  exp_d;   // One-cycle end-of-period pulse
    logic          ms_tick;         // Millisecond enable

    // Divider restarts with each run so the period is exact from start
    always_comb begin
        ms_tick = run && (div_q == DIV_LAST);
        div_d   = div_q;
        ms_d    = ms_q;
        exp_d   = 1'b0;
        if (!run) begin
            div_d = '0;
            ms_d  = '0;
        end else if (ms_tick) begin
            div_d = '0;
            ms_d  = 11'(ms_q + 11'h001);
            // Limit of zero cannot occur: shortest period is 2 ms
            exp_d = (11'(ms_q + 11'h001) == limit_ms);
        end else begin
            div_d = DW'(div_q + 1'b1);
        end
    end

    // Register only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= '0;
            ms_q  <= '0;
            exp_q <= 1'b0;
        end else begin
            div_q <= div_d;
            ms_q  <= ms_d;
            exp_q <= exp_d;
        end
    end

    // A pulse left over after the host stopped the flash is dropped,
    // so it cannot clear a mode written in the same cycle
    assign expired    = exp_q && run;
    assign elapsed_ms = ms_q;

endmodule // flash_period_timer

// ### hdl/flash_timer_mode_control.sv
// Flash duration and operating mode registers with the sink control core.
// Operation
// - Codes 00-7F: period is (code+1) x 2 ms
// - Codes 80-FF: (code-127) x 8 + 256 ms
// - From code 80 steps are 8 ms
// - Mode 00: shutdown, or external torch
// - Indicator: six low bits, PWM at 31.25 kHz
// - Assist: seven low bits, top bit ignored
// - Flash: full level, auto-clear enable and mode
// - Mode selector is bits 1:0, resets 00
// - Duration is full 8-bit read/write field
// - Enable bit gates sinks except in mode 00, resets 0
`timescale 1ns/1ps
module flash_timer_mode_control
    import flash_ctrl_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Register access from the serial control front end
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Settings held in neighbouring registers
    input  wire logic [7:0] sink1_current_level,
    input  wire logic [7:0] sink2_current_level,
    input  wire logic [1:0] ext_torch_sel,
    input  wire logic [3:0] indicator_duty,
    // Sink control
    output logic [7:0]      sink1_drive,
    output logic [7:0]      sink2_drive,
    output logic            sink_enable,
    output logic            flash_active,
    output logic            flash_done
);

    // ---------------------------------------------------------------
    // Duration decoding
    // ---------------------------------------------------------------

    // Two-segment code to milliseconds; fine steps give short flashes
    // precision, coarse steps reach long timeouts in one byte
    function automatic logic [10:0] period_ms(input logic [7:0] code);
        logic [10:0] c;
        c = {3'h0, code};
        if (!code[7]) begin
            period_ms = 11'((c + 11'h001) * SHORT_STEP_MS);
        end else begin
            period_ms = 11'((c - LONG_BASE_CODE) * LONG_STEP_MS
                            + LONG_BASE_MS);
        end
    endfunction

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [7:0] duration_q, duration_d;   // Flash duration code
    op_mode_t   mode_q,     mode_d;       // Operating mode selector
    logic       out_on_q,   out_on_d;     // Sink enable bit
    logic [7:0] rdata_q,    rdata_d;      // Read data register
    logic       wr_dur;                   // Write to duration register
    logic       wr_ctl;                   // Write to control register
    logic       timer_exp;                // Flash period elapsed
    logic [10:0] limit_ms;                // Decoded period

    assign wr_dur   = reg_wr && (reg_addr == DURATION_OFFSET);
    assign wr_ctl   = reg_wr && (reg_addr == CONTROL_OFFSET);
    assign limit_ms = period_ms(duration_q);

    // Next register values; a host write in the expiry cycle wins,
    // so a new request issued right at the end is not discarded
    always_comb begin
        duration_d = duration_q;
        mode_d     = mode_q;
        out_on_d   = out_on_q;
        rdata_d    = rdata_q;
        // Flash pulse over: drop enable and return to shutdown
        if (timer_exp) begin
            mode_d   = MODE_SHUTDOWN;
            out_on_d = 1'b0;
        end
        if (wr_dur) begin
            duration_d = reg_wdata;
        end
        if (wr_ctl) begin
            mode_d   = op_mode_t'(reg_wdata[MODE_MSB:MODE_LSB]);
            out_on_d = reg_wdata[OUT_ON_BIT];
        end
        // Read data: reserved bits read as zero
        if (reg_rd) begin
            case (reg_addr)
                DURATION_OFFSET: begin
                    rdata_d = duration_q;
                end
                CONTROL_OFFSET: begin
                    rdata_d = READ_NONE;
                    rdata_d[MODE_MSB:MODE_LSB] = mode_q;
                    rdata_d[RSVD_BIT]          = 1'b0;
                    rdata_d[OUT_ON_BIT]        = out_on_q;
                end
                default: begin
                    rdata_d = READ_NONE;
                end
            endcase
        end
    end

    // Register only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            duration_q <= DURATION_RESET;
            mode_q     <= MODE_SHUTDOWN;
            out_on_q   <= 1'b0;
            rdata_q    <= READ_NONE;
        end else begin
            duration_q <= duration_d;
            mode_q     <= mode_d;
            out_on_q   <= out_on_d;
            rdata_q    <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ---------------------------------------------------------------
    // Flash period timer
    // ---------------------------------------------------------------
    logic flash_run;   // Flash mode with sinks enabled

    assign flash_run = (mode_q == MODE_FLASH) && out_on_q;

    // Ends the pulse without host help, protecting the LED
    flash_period_timer #(
        .MS_CYCLES_P (MS_CYCLES_P)
    ) u_timer (
        .clk        (clk),
        .reset_n    (reset_n),
        .run        (flash_run),
        .limit_ms   (limit_ms),
        .expired    (timer_exp),
        .elapsed_ms ()
    );

    // ---------------------------------------------------------------
    // Indicator PWM, 31.25 kHz in sixteenths of duty
    // ---------------------------------------------------------------
    localparam int PW = $clog2(PWM_CYCLES);
    localparam logic [PW-1:0] PWM_LAST = PW'(PWM_CYCLES - 1);
    localparam logic [PW-1:0] SLOT     = PW'(SLOT_CYCLES);

    logic [PW-1:0] pwm_q, pwm_d;   // Position within PWM period
    logic          pwm_on;         // High part of the PWM period

    // Free running; the duty code n gives (n+1)/16 on time
    always_comb begin
        pwm_d = (pwm_q == PWM_LAST) ? '0 : PW'(pwm_q + 1'b1);
    end

    // Register only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_q <= '0;
        end else begin
            pwm_q <= pwm_d;
        end
    end

    assign pwm_on = pwm_q < PW'(({1'b0, indicator_duty} + 5'h01) * SLOT);

    // ---------------------------------------------------------------
    // Sink drive selection
    // ---------------------------------------------------------------
    logic [7:0] drv1_q, drv1_d;   // Sink 1 level
    logic [7:0] drv2_q, drv2_d;   // Sink 2 level
    logic       en_q,   en_d;     // Sinks conducting
    logic       fa_q,   fa_d;     // Flash pulse in progress
    logic       fd_q,   fd_d;     // Flash end pulse
    logic [7:0] mask;             // Level mask for the active mode

    // Each mode below flash narrows the level so lower modes cannot reach flash
    // current; external torch reuses the assist ceiling
    always_comb begin
        mask = MASK_FULL;
        en_d = 1'b0;
        case (mode_q)
            MODE_SHUTDOWN: begin
                mask = MASK_LOW7;
                en_d = (ext_torch_sel == EXT_TORCH_SEL);
            end
            MODE_INDICATOR: begin
                mask = MASK_LOW6;
                en_d = out_on_q && pwm_on;
            end
            MODE_ASSIST: begin
                mask = MASK_LOW7;
                en_d = out_on_q;
            end
            MODE_FLASH: begin
                mask = MASK_FULL;
                en_d = out_on_q && !timer_exp;
            end
            default: begin
                mask = MASK_LOW6;
                en_d = 1'b0;
            end
        endcase
        drv1_d = sink1_current_level & mask;
        drv2_d = sink2_current_level & mask;
        fa_d   = flash_run && !timer_exp;
        fd_d   = timer_exp;
    end

    // Register only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drv1_q <= '0;
            drv2_q <= '0;
            en_q   <= 1'b0;
            fa_q   <= 1'b0;
            fd_q   <= 1'b0;
        end else begin
            drv1_q <= drv1_d;
            drv2_q <= drv2_d;
            en_q   <= en_d;
            fa_q   <= fa_d;
            fd_q   <= fd_d;
        end
    end

    assign sink1_drive  = drv1_q;
    assign sink2_drive  = drv2_q;
    assign sink_enable  = en_q;
    assign flash_active = fa_q;
    assign flash_done   = fd_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_short_period: assert property (
        @(posedge clk) disable iff (!reset_n)
        (duration_q == 8'h23) |-> (limit_ms == 11'h048))
        else $error("Default code must give 72 ms");

    a_long_period: assert property (
        @(posedge clk) disable iff (!reset_n)
        (duration_q == 8'hff) |-> (limit_ms == 11'h500))
        else $error("Code ff must give 1280 ms");

    a_long_step: assert property (
        @(posedge clk) disable iff (!reset_n)
        (duration_q == 8'h80) |-> (limit_ms == 11'h108))
        else $error("Code 80 must give 264 ms");

    a_shutdown_dark: assert property (
        @(posedge clk) disable iff (!reset_n)
        (mode_q == MODE_SHUTDOWN && ext_torch_sel != EXT_TORCH_SEL)
        |=> !sink_enable)
        else $error("Sinks on in shutdown");

    a_indicator_bits: assert property (
        @(posedge clk) disable iff (!reset_n)
        (mode_q == MODE_INDICATOR) |=> (sink1_drive[7:6] == 2'b00
                                        && sink2_drive[7:6] == 2'b00))
        else $error("Indicator level above six bits");

    a_assist_msb: assert property (
        @(posedge clk) disable iff (!reset_n)
        (mode_q == MODE_ASSIST) |=> (sink1_drive == (
            $past(sink1_current_level) & MASK_LOW7)))
        else $error("Assist level not seven bits");

    a_flash_clear: assert property (
        @(posedge clk) disable iff (!reset_n)
        (timer_exp && !wr_ctl) |=> (mode_q == MODE_SHUTDOWN && !out_on_q
                                     && !sink_enable))
        else $error("Flash end did not clear mode");

    a_mode_write: assert property (
        @(posedge clk) disable iff (!reset_n)
        wr_ctl |=> (mode_q == $past(reg_wdata[MODE_MSB:MODE_LSB])
                    && out_on_q == $past(reg_wdata[OUT_ON_BIT])))
        else $error("Control write not stored");

    a_duration_write: assert property (
        @(posedge clk) disable iff (!reset_n)
        wr_dur |=> (duration_q == $past(reg_wdata)))
        else $error("Duration write not stored");

    a_enable_gate: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!out_on_q && mode_q != MODE_SHUTDOWN) |=> !sink_enable)
        else $error("Sinks on with enable clear");

    a_expire_cause: assert property (
        @(posedge clk) disable iff (!reset_n)
        timer_exp |-> ($past(flash_run, 1) && flash_run))
        else $error("Timer ended outside a flash");

endmodule // flash_timer_mode_control

// ### tb/flash_host_model.sv
// Host processor model driving the register byte port.
`timescale 1ns/1ps
module flash_host_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    // Idle lines show the inverse, so stale values are never trusted
    task automatic release_bus();
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    // One-cycle write; reserved control bit 2 always written as zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = (a == 8'h06) ? (d & 8'hfb) : d;
        reg_wr    = 1'b1;
        release_bus();
    endtask

    // One-cycle read; data taken once it has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        release_bus();
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule // flash_host_model

// ### tb/flash_timer_mode_control_bench.sv
// Self-checking bench for the flash timer and mode control block.
`timescale 1ns/1ps
module flash_timer_mode_control_bench;
    import flash_ctrl_pkg::*;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    localparam int MSC = 10;    // Cycles per simulated millisecond
    logic        clk = 1'b0;    // Bench clock
    logic        reset_n = 1'b0; // Reset, active low
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
    logic        reg_wr, reg_rd;
    logic [7:0]  lvl1 = 8'h00, lvl2 = 8'h00; // Sink levels
    logic [1:0]  torch = 2'h0;  // Torch selector
    logic [3:0]  duty = 4'h0;   // Indicator duty
    logic [7:0]  sink1_drive, sink2_drive;
    logic        sink_enable, flash_active, flash_done;
    int          miscompares = 0;
    int          tests_run = 0;

    flash_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    flash_timer_mode_control #(.MS_CYCLES_P(MSC)) uut (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sink1_current_level(lvl1), .sink2_current_level(lvl2),
        .ext_torch_sel(torch), .indicator_duty(duty),
        .sink1_drive(sink1_drive), .sink2_drive(sink2_drive),
        .sink_enable(sink_enable), .flash_active(flash_active),
        .flash_done(flash_done));

    // Clock generator
    initial begin
        forever #4 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    // Period in ms for a duration code, two segments
    function automatic int period_ms(input logic [7:0] c);
        if (c < 8'h80) return (int'(c) + 1) * 2;
        return (int'(c) - 127) * 8 + 256;
    endfunction

    // Level mask per mode; a limitation: torch uses the assist mask
    function automatic logic [7:0] mask_of(input logic [1:0] m);
        case (m)
            2'b01:   return MASK_LOW6;
            2'b11:   return MASK_FULL;
            default: return MASK_LOW7;
        endcase
    endfunction

    // One complete flash with a given code, timing checked within 2
    task automatic run_flash(input logic [7:0] code);
        int n;
        int e;
        n = 0;
        // Long flashes run below full current to spare the device
        if (period_ms(code) > 120) begin
            lvl1 = lvl1 & MASK_LOW7;
            lvl2 = lvl2 & MASK_LOW7;
        end
        host.wr(DURATION_OFFSET, code);
        host.wr(CONTROL_OFFSET, 8'h0b);
        repeat (4) if (flash_active !== 1'b1) @(negedge clk);
        check(sink1_drive, lvl1, "flash drive");
        while (flash_active === 1'b1 && n < 20000) begin
            n++;
            @(negedge clk);
        end
        e = period_ms(code) * MSC;
        check(n >= e - 2 && n <= e + 2, 1, "period");
        check(flash_done, 1'b1, "done pulse");
        @(negedge clk);
        check(sink_enable, 1'b0, "sinks off");
        host.rd(CONTROL_OFFSET, rv);
        check(rv, 8'h00, "auto clear");
    endtask

    // Static mode: drives masked, enable as expected
    task automatic run_mode(input logic [7:0] ctl, input logic en);
        host.wr(CONTROL_OFFSET, ctl);
        repeat (3) @(negedge clk);
        check(sink1_drive, lvl1 & mask_of(ctl[1:0]), "drive1");
        check(sink2_drive, lvl2 & mask_of(ctl[1:0]), "drive2");
        check(sink_enable, en, "enable");
    endtask

    // ---------------------------------------------------------------
    // Closing and watchdog
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Longest run is well under this span
    initial begin
        #(8 * 90000);
        miscompares++;
        test_done();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        int on;
        logic [7:0] wv;
        void'($urandom(32'h8672));
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        host.rd(DURATION_OFFSET, rv);
        check(rv, DURATION_RESET, "duration reset");
        host.rd(CONTROL_OFFSET, rv);
        check(rv, 8'h00, "control reset");
        host.rd(8'h09, rv);
        check(rv, READ_NONE, "unmapped");
        wv = 8'($urandom());
        host.wr(DURATION_OFFSET, wv);
        host.rd(DURATION_OFFSET, rv);
        check(rv, wv, "duration read back");
        host.wr(CONTROL_OFFSET, 8'hf2);
        host.rd(CONTROL_OFFSET, rv);
        check(rv, 8'h02, "upper bits dropped");
        // Mode sweep with random levels
        lvl1 = 8'($urandom());
        lvl2 = 8'($urandom()) | 8'h80;
        torch = 2'h1;
        run_mode(8'h08, 1'b0);
        torch = EXT_TORCH_SEL;
        run_mode(8'h00, 1'b1);
        run_mode(8'h0a, 1'b1);
        run_mode(8'h02, 1'b0);
        // Torch off again, else shutdown after a flash keeps sinks on
        torch = 2'h0;
        // Indicator duty over one period, corner and random
        for (int k = 0; k < 2; k++) begin
            duty = (k == 0) ? 4'h0 : 4'($urandom());
            host.wr(CONTROL_OFFSET, 8'h09);
            repeat (3) @(negedge clk);
            check(sink1_drive, lvl1 & MASK_LOW6, "ind drive");
            on = 0;
            repeat (PWM_CYCLES) begin
                @(negedge clk);
                if (sink_enable === 1'b1) on++;
            end
            check(on >= (duty + 1) * SLOT_CYCLES - 2 &&
                  on <= (duty + 1) * SLOT_CYCLES + 2, 1, "duty");
        end
        host.wr(CONTROL_OFFSET, 8'h00);
        // Flash timing at segment edges and at random
        run_flash(8'h00);
        run_flash(8'h23);
        run_flash(8'h7f);
        run_flash(8'h80);
        run_flash(8'h81);
        run_flash(8'h80 | 8'($urandom()));
        run_flash(8'hff);
        test_done();
    end
endmodule // flash_timer_mode_control_bench
